/* include/adirq_pkg.sv */
`default_nettype none

package adirq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and measurement timing
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned MS_PER_S    = 1000;
   localparam int unsigned TICK_CYC    = CLK_HZ / MS_PER_S;
   localparam int unsigned TICK_W      = 20;
   localparam logic [9:0]  DUR_BASE_MS = 10'h032;
   localparam logic [9:0]  DUR_STEP_MS = 10'h064;
   localparam logic [9:0]  DUR_MAX_MS  = 10'h3E8;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] REG_CTRL  = 8'h02;
   localparam logic [7:0] REG_FLAGS = 8'h03;
   localparam logic [7:0] REG_MASK  = 8'h05;
   localparam logic [7:0] REG_CODE  = 8'h07;
   localparam logic [7:0] REG_TSEL  = 8'h08;
   localparam logic [7:0] REG_LIVE  = 8'h09;
   localparam logic [7:0] REG_CLASS = 8'h0A;
   localparam logic [7:0] REG_RAW   = 8'h0B;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and field positions
   localparam logic [7:0] CTRL_RST   = 8'hD1;
   localparam logic [7:0] REG_ZERO   = 8'h00;
   localparam logic [7:0] EVT_USED   = 8'h7E;
   localparam logic [7:0] CTRL_SWRST = 8'h40;
   localparam int unsigned CTRL_DCD_BIT   = 7;
   localparam int unsigned CTRL_SWRST_BIT = 6;
   localparam int unsigned CTRL_IDDIS_BIT = 5;
   localparam int unsigned CTRL_GMASK_BIT = 0;
   localparam int unsigned EV_OC   = 6;
   localparam int unsigned EV_OV   = 5;
   localparam int unsigned EV_MIC  = 4;
   localparam int unsigned EV_CODE = 3;
   localparam int unsigned EV_VBUS = 2;
   localparam int unsigned EV_BC   = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic       short_det;
      logic       oc;
      logic       ov;
      logic       mic;
      logic       not_float;
      logic       vbus;
      logic       bc_active;
      logic       dcd;
      logic       dock;
      logic       dcp;
      logic       cdp;
      logic       sdp;
      logic [4:0] code;
      logic [7:0] raw;
   } adirq_det_t;

   localparam int unsigned DET_W = $bits(adirq_det_t);

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_RX   = 3'b001,
      I2C_ACK  = 3'b010,
      I2C_TX   = 3'b011,
      I2C_RACK = 3'b100
   } adirq_i2c_t;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_PTR  = 2'b01,
      PH_DATA = 2'b10
   } adirq_phase_t;

   typedef struct packed {
      adirq_det_t          prev;
      logic                scl_q;
      logic                sda_q;
      adirq_i2c_t          i2c;
      adirq_phase_t        ph;
      logic [3:0]          bits;
      logic [7:0]          shr;
      logic [7:0]          ptr;
      logic                rd;
      logic                ackd;
      logic                sda_oe;
      logic                sda_val;
      logic [7:0]          ctrl;
      logic [7:0]          flags;
      logic [7:0]          mask;
      logic [4:0]          code;
      logic [3:0]          tsel;
      logic [7:0]          raw;
      logic                run;
      logic [TICK_W-1:0]   tick;
      logic [9:0]          ms;
      logic                int_b;
   } adirq_state_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Window length in ms for a timing code
   function automatic logic [9:0] adirq_dur_ms(input logic [3:0] c);
      if (c <= 4'h3) begin
         return DUR_BASE_MS * ({6'h00, c} + 10'h001);
      end else if (c <= 4'hB) begin
         return DUR_STEP_MS * ({6'h00, c} - 10'h001);
      end
      return DUR_MAX_MS;
   endfunction : adirq_dur_ms

endpackage : adirq_pkg

`default_nettype wire

/* src/adirq_regs.sv */
`default_nettype none

module adirq_regs #(
   parameter logic [6:0]  DEV_ADDR    = 7'h25,               // Arbitrary value
   parameter int unsigned TICK_CYCLES = adirq_pkg::TICK_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire adirq_pkg::adirq_det_t  det_in,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe,
   output logic                        int_b,
   output logic                        dcd_timeout_en,
   output logic                        measure_active
);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks and constants

   if (TICK_CYCLES < 1 || TICK_CYCLES > (2 ** adirq_pkg::TICK_W)) begin : g_bad_tick
      $error("TICK_CYCLES out of range for the tick counter");
   end

   localparam logic [adirq_pkg::TICK_W-1:0] TICK_LAST =
      adirq_pkg::TICK_W'(TICK_CYCLES - 1);

   localparam adirq_pkg::adirq_state_t ST_RST = '{
      ctrl    : adirq_pkg::CTRL_RST,
      int_b   : 1'b1,
      i2c     : adirq_pkg::I2C_IDLE,
      ph      : adirq_pkg::PH_ADDR,
      default : '0
   };

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   adirq_pkg::adirq_state_t cur;
   adirq_pkg::adirq_state_t next_cur;
   adirq_pkg::adirq_det_t   det;
   logic                    scl;
   logic                    sda;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    start;
   logic                    stop;
   logic                    load;
   logic                    swrst;
   logic                    hold;
   logic                    floated;
   logic                    dis;
   logic                    retime;
   logic [7:0]              evt;
   logic [7:0]              rclr;
   logic [7:0]              rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin and detector inputs are asynchronous: two flops before use.
   // Code and raw value are multi-bit; they are only sampled at the end of a
   // measurement window, long after the detector output has settled.

   adirq_sync #(
      .W (adirq_pkg::DET_W + 2)
   ) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({det_in, scl_in, sda_in}),
      .q     ({det, scl, sda})
   );

   assign scl_rise = scl & ~cur.scl_q;
   assign scl_fall = ~scl & cur.scl_q;
   assign start    = scl & cur.scl_q & cur.sda_q & ~sda;
   assign stop     = scl & cur.scl_q & ~cur.sda_q & sda;
   assign load     = scl_fall & ((cur.i2c == adirq_pkg::I2C_ACK && cur.rd) ||
                                 (cur.i2c == adirq_pkg::I2C_RACK && cur.ackd));
   assign dis      = cur.ctrl[adirq_pkg::CTRL_IDDIS_BIT];
   assign hold     = dis & (cur.code != 5'h00);
   assign floated  = ~det.not_float;

   ////////////////////////////////////////////////////////////////////////////////
   // Register read decode

   function automatic logic [7:0] read_reg(
      input logic [7:0]              a,
      input adirq_pkg::adirq_state_t s,
      input adirq_pkg::adirq_det_t   d
   );
      unique case (a)
         adirq_pkg::REG_CTRL:  return s.ctrl;
         adirq_pkg::REG_FLAGS: return s.flags;
         adirq_pkg::REG_MASK:  return s.mask;
         adirq_pkg::REG_CODE:  return {3'h0, s.code};
         adirq_pkg::REG_TSEL:  return {4'h0, s.tsel};
         adirq_pkg::REG_LIVE:  return {d.short_det, d.oc, d.ov, d.mic,
                                      d.not_float, d.vbus, d.bc_active,
                                      d.dcd};
         adirq_pkg::REG_CLASS: return {2'h0, d.dock, 2'h0,
                                      d.dcp, d.cdp, d.sdp};
         adirq_pkg::REG_RAW:   return s.raw;
         default:              return adirq_pkg::REG_ZERO;
      endcase
   endfunction : read_reg

   assign rdata = read_reg(cur.ptr, cur, det);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_cur       = cur;
      swrst          = 1'b0;
      evt            = adirq_pkg::REG_ZERO;
      rclr           = adirq_pkg::REG_ZERO;
      retime         = 1'b0;
      next_cur.scl_q = scl;
      next_cur.sda_q = sda;
      next_cur.prev  = det;

      // I2C slave: open-drain, so oe high pulls the line low
      unique case (cur.i2c)
         adirq_pkg::I2C_IDLE: begin
            next_cur.sda_oe = 1'b0;
         end
         adirq_pkg::I2C_RX: begin
            if (scl_rise) begin
               next_cur.shr  = {cur.shr[6:0], sda};
               next_cur.bits = cur.bits + 4'h1;
            end else if (scl_fall && cur.bits == 4'h8) begin
               next_cur.bits   = 4'h0;
               next_cur.i2c    = adirq_pkg::I2C_ACK;
               next_cur.sda_oe = 1'b1;
               unique case (cur.ph)
                  adirq_pkg::PH_ADDR: begin
                     if (cur.shr[7:1] == DEV_ADDR) begin
                        next_cur.rd = cur.shr[0];
                        next_cur.ph = cur.shr[0] ? adirq_pkg::PH_DATA : adirq_pkg::PH_PTR;
                     end else begin
                        next_cur.i2c    = adirq_pkg::I2C_IDLE;
                        next_cur.sda_oe = 1'b0;
                     end
                  end
                  adirq_pkg::PH_PTR: begin
                     next_cur.ptr = cur.shr;
                     next_cur.ph  = adirq_pkg::PH_DATA;
                  end
                  default: begin
                     next_cur.ptr = cur.ptr + 8'h01;
                     unique case (cur.ptr)
                        adirq_pkg::REG_CTRL: begin
                           // Reset bit always reads back one; writing zero pulses it
                           next_cur.ctrl = cur.shr | adirq_pkg::CTRL_SWRST;
                           swrst = ~cur.shr[adirq_pkg::CTRL_SWRST_BIT];
                        end
                        adirq_pkg::REG_MASK: begin
                           next_cur.mask = cur.shr & adirq_pkg::EVT_USED;
                        end
                        adirq_pkg::REG_TSEL: begin
                           next_cur.tsel = cur.shr[3:0];
                           retime        = 1'b1;
                        end
                        default: begin
                        end
                     endcase
                  end
               endcase
            end
         end
         adirq_pkg::I2C_ACK: begin
            if (scl_fall && !cur.rd) begin
               next_cur.sda_oe = 1'b0;
               next_cur.i2c    = adirq_pkg::I2C_RX;
            end
         end
         adirq_pkg::I2C_TX: begin
            if (scl_fall) begin
               if (cur.bits == 4'h7) begin
                  next_cur.sda_oe = 1'b0;
                  next_cur.i2c    = adirq_pkg::I2C_RACK;
               end else begin
                  next_cur.bits   = cur.bits + 4'h1;
                  next_cur.shr    = {cur.shr[6:0], 1'b0};
                  next_cur.sda_oe = ~cur.shr[6];
               end
            end
         end
         adirq_pkg::I2C_RACK: begin
            if (scl_rise) begin
               next_cur.ackd = ~sda;
            end else if (scl_fall && !cur.ackd) begin
               next_cur.i2c = adirq_pkg::I2C_IDLE;
            end
         end
         default: begin
            next_cur.i2c = adirq_pkg::I2C_IDLE;
         end
      endcase

      // Byte load for a read; the flag register clears what it hands out
      if (load) begin
         next_cur.shr    = rdata;
         next_cur.bits   = 4'h0;
         next_cur.sda_oe = ~rdata[7];
         next_cur.i2c    = adirq_pkg::I2C_TX;
         next_cur.ptr    = cur.ptr + 8'h01;
         if (cur.ptr == adirq_pkg::REG_FLAGS) begin
            rclr = rdata;
         end
      end

      if (start) begin
         next_cur.i2c    = adirq_pkg::I2C_RX;
         next_cur.ph     = adirq_pkg::PH_ADDR;
         next_cur.bits   = 4'h0;
         next_cur.sda_oe = 1'b0;
      end else if (stop) begin
         next_cur.i2c    = adirq_pkg::I2C_IDLE;
         next_cur.sda_oe = 1'b0;
      end

      // Resistor measurement window
      next_cur.run = ~hold;
      if (hold) begin
         // Stopped after a resistance; a floating pin, a software reset or clearing the disable bit restarts it
         next_cur.tick = '0;
         next_cur.ms   = 10'h000;
         if (floated) begin
            next_cur.code = 5'h00;
            next_cur.raw  = 8'h00;
            evt[adirq_pkg::EV_CODE] = 1'b1;
         end
      end else if (cur.tick == TICK_LAST) begin
         next_cur.tick = '0;
         if (cur.ms + 10'h001 >= adirq_pkg::adirq_dur_ms(cur.tsel)) begin
            next_cur.ms   = 10'h000;
            next_cur.code = det.code;
            next_cur.raw  = det.raw;
            if (det.code != cur.code && (!dis || det.code == 5'h00)) begin
               evt[adirq_pkg::EV_CODE] = 1'b1;
            end
         end else begin
            next_cur.ms = cur.ms + 10'h001;
         end
      end else begin
         next_cur.tick = cur.tick + 1'b1;
      end

      // New timing code restarts the window; a shorter code never sees a stale count
      if (retime) begin
         next_cur.tick = '0;
         next_cur.ms   = 10'h000;
      end

      // Level changes; charger completion is the fall of its busy level
      evt[adirq_pkg::EV_OC]   = det.oc ^ cur.prev.oc;
      evt[adirq_pkg::EV_OV]   = det.ov ^ cur.prev.ov;
      evt[adirq_pkg::EV_MIC]  = det.mic ^ cur.prev.mic;
      evt[adirq_pkg::EV_VBUS] = det.vbus ^ cur.prev.vbus;
      evt[adirq_pkg::EV_BC]   = cur.prev.bc_active & ~det.bc_active;

      // Set wins over the read clear
      next_cur.flags = ((cur.flags & ~rclr) | evt) & adirq_pkg::EVT_USED;

      if (swrst) begin
         next_cur.flags = adirq_pkg::REG_ZERO;
         next_cur.mask  = adirq_pkg::REG_ZERO;
         next_cur.code  = 5'h00;
         next_cur.tsel  = 4'h0;
         next_cur.raw   = 8'h00;
         next_cur.tick  = '0;
         next_cur.ms    = 10'h000;
      end

      next_cur.int_b = ~((|(next_cur.flags & ~next_cur.mask & adirq_pkg::EVT_USED)) &
                         ~next_cur.ctrl[adirq_pkg::CTRL_GMASK_BIT]);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur <= ST_RST;
      end else begin
         cur <= next_cur;
      end
   end

   assign sda_out        = cur.sda_val;
   assign sda_oe         = cur.sda_oe;
   assign int_b          = cur.int_b;
   assign dcd_timeout_en = cur.ctrl[adirq_pkg::CTRL_DCD_BIT];
   assign measure_active = cur.run;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (!rst_b);

   sequence s_flag_read;
      load && cur.ptr == adirq_pkg::REG_FLAGS;
   endsequence

   property p_oc_evt;
      $changed(det.oc) && !swrst |=> cur.flags[adirq_pkg::EV_OC];
   endproperty
   a_oc_evt: assert property (p_oc_evt) else $error("over-current change not flagged");

   property p_ov_evt;
      $changed(det.ov) && !swrst |=> cur.flags[adirq_pkg::EV_OV];
   endproperty
   a_ov_evt: assert property (p_ov_evt) else $error("over-voltage change not flagged");

   property p_vbus_evt;
      $changed(det.vbus) && !swrst |=> cur.flags[adirq_pkg::EV_VBUS];
   endproperty
   a_vbus_evt: assert property (p_vbus_evt) else $error("vbus change not flagged");

   property p_bc_evt;
      $fell(det.bc_active) && !swrst |=> cur.flags[adirq_pkg::EV_BC];
   endproperty
   a_bc_evt: assert property (p_bc_evt) else $error("charger completion not flagged");

   property p_rd_clear;
      s_flag_read |=> (cur.flags & ~$past(evt)) == adirq_pkg::REG_ZERO;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("flag read did not clear");

   property p_int;
      (|(cur.flags & ~cur.mask & adirq_pkg::EVT_USED)) &&
      !cur.ctrl[adirq_pkg::CTRL_GMASK_BIT] |-> !int_b;
   endproperty
   a_int: assert property (p_int) else $error("interrupt not raised");

   property p_hold;
      dis && cur.code != 5'h00 |=> !measure_active;
   endproperty
   a_hold: assert property (p_hold) else $error("measurement not stopped");

   property p_dur;
      cur.ms < adirq_pkg::adirq_dur_ms(cur.tsel) || !cur.run;
   endproperty
   a_dur: assert property (p_dur) else $error("window count past its length");

   property p_swrst;
      swrst |=> cur.flags == 8'h00 && cur.mask == 8'h00 && cur.code == 5'h00;
   endproperty
   a_swrst: assert property (p_swrst) else $error("software reset left state");

endmodule : adirq_regs

`default_nettype wire

/* src/adirq_sync.sv */
`default_nettype none

module adirq_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } adirq_sync_t;

   adirq_sync_t cur;
   adirq_sync_t next_cur;

   if (W < 1) begin : g_bad_w
      $error("adirq_sync width must be at least one");
   end

   // First stage feeds only the second stage
   always_comb begin
      next_cur.s1 = d;
      next_cur.s2 = cur.s1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign q = cur.s2;

endmodule : adirq_sync

`default_nettype wire

/* verification/adirq_host.sv */
`default_nettype none

module adirq_host #(
   parameter logic [6:0]  ADDR = 7'h25,
   parameter int unsigned Q    = 5
) (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 100ps;

   int miss;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      miss = 0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : hold

   ////////////////////////////////////////////////////////////////////////////////
   // Data moves only a few cycles after the clock line falls, so the synced
   // copies inside the device never see a data edge while the clock is high
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      hold(Q);
      scl = 1'b1;
      hold(Q);
      r = sda;
      hold(Q);
      scl = 1'b0;
      hold(Q);
   endtask : bit_io

   task automatic start;
      sda_low = 1'b0;
      hold(Q);
      scl = 1'b1;
      hold(Q);
      sda_low = 1'b1;
      hold(Q);
      scl = 1'b0;
      hold(Q);
   endtask : start

   task automatic stop;
      sda_low = 1'b1;
      hold(Q);
      scl = 1'b1;
      hold(Q);
      sda_low = 1'b0;
      hold(Q);
   endtask : stop

   task automatic byte_tx(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      if (r !== 1'b0) begin
         miss++;
      end
   endtask : byte_tx

   task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
      start();
      byte_tx({ADDR, 1'b0});
      byte_tx(p);
      byte_tx(d);
      stop();
   endtask : write_reg

   // Single byte read; the closing NACK ends the burst
   task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
      logic r;
      start();
      byte_tx({ADDR, 1'b0});
      byte_tx(p);
      start();
      byte_tx({ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(1'b1, r);
      stop();
   endtask : read_reg

endmodule : adirq_host

`default_nettype wire

/* verification/test_accessory_detect_irq_status_regs.sv */
`default_nettype none

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module test_accessory_detect_irq_status_regs;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned TICKS = 4;

   logic                  clk;
   logic                  rst_b;
   logic                  scl;
   logic                  sda_low;
   logic                  sda;
   logic                  sda_out;
   logic                  sda_oe;
   logic                  int_b;
   logic                  dcd_en;
   logic                  meas;
   adirq_pkg::adirq_det_t det;
   int                    err_total;
   int                    samples_checked;
   logic [7:0]            regs [8] = '{8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};

   // Pull-up on the data line; either party may pull it low
   assign sda = ~((sda_oe & ~sda_out) | sda_low);

   adirq_regs #(.TICK_CYCLES(TICKS)) dut (
      .clk            (clk),
      .rst_b          (rst_b),
      .det_in         (det),
      .scl_in         (scl),
      .sda_in         (sda),
      .sda_out        (sda_out),
      .sda_oe         (sda_oe),
      .int_b          (int_b),
      .dcd_timeout_en (dcd_en),
      .measure_active (meas)
   );

   adirq_host host (
      .clk     (clk),
      .sda     (sda),
      .scl     (scl),
      .sda_low (sda_low)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      host.read_reg(p, d);
      `CHK(d, e)
   endtask : rdchk

   // Detector levels change after an edge, then settle past the two sync flops
   task automatic apply_det(input logic [24:0] v);
      @(posedge clk);
      #1 det = v;
      repeat (12) @(posedge clk);
      #1;
   endtask : apply_det

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // About half of this span is needed by the whole sequence
   initial begin
      repeat (95000) @(posedge clk);
      err_total++;
      stop_test();
   end

   initial begin
      logic [24:0] flip;
      rst_b = 1'b0;
      det = '0;
      err_total = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      foreach (regs[i]) begin
         rdchk(regs[i], 8'h00);
      end
      host.write_reg(8'h05, 8'hFF);
      rdchk(8'h05, 8'h7E);
      $display("test reset_and_mask done");

      host.write_reg(8'h02, 8'hD0);
      for (int i = 1; i <= 6; i++) begin
         if (i != 3) begin
            flip = 25'h1 << (17 + i);
            host.write_reg(8'h05, 8'h7E);
            apply_det(det ^ flip);
            `CHK(int_b, 1'b1)
            rdchk(8'h09, 8'h01 << i);
            rdchk(8'h03, (i == 1) ? 8'h00 : 8'h01 << i);
            host.write_reg(8'h05, 8'h00);
            apply_det(det ^ flip);
            `CHK(int_b, 1'b0)
            rdchk(8'h03, 8'h01 << i);
            `CHK(int_b, 1'b1)
         end
      end
      host.write_reg(8'h02, 8'hD1);
      apply_det(det ^ (25'h1 << 23));
      `CHK(int_b, 1'b1)
      rdchk(8'h03, 8'h40);
      apply_det(det ^ (25'h1 << 23));
      rdchk(8'h03, 8'h40);
      $display("test events done");

      // Window of timing code 0 is 50 ms of 4 cycles, 200 cycles; wait two windows as its phase is unknown
      apply_det(25'h1_05A5);
      repeat (420) @(posedge clk);
      rdchk(8'h07, 8'h05);
      rdchk(8'h0B, 8'hA5);
      rdchk(8'h03, 8'h08);
      host.write_reg(8'h08, 8'hFF);
      rdchk(8'h08, 8'h0F);
      host.write_reg(8'h08, 8'h00);
      apply_det(det | 25'h1_13_E000);
      rdchk(8'h0A, 8'h27);
      rdchk(8'h09, 8'h89);
      host.write_reg(8'h0A, 8'hFF);
      rdchk(8'h0A, 8'h27);
      $display("test measure_and_class done");

      host.write_reg(8'h02, 8'hF0);
      apply_det({det[24:13], 5'h09, det[7:0]});
      repeat (420) @(posedge clk);
      rdchk(8'h07, 8'h05);
      `CHK(meas, 1'b0)
      rdchk(8'h03, 8'h00);
      apply_det({det[24:21], 1'b0, det[19:13], 13'h0000});
      repeat (20) @(posedge clk);
      rdchk(8'h07, 8'h00);
      rdchk(8'h03, 8'h08);
      `CHK(meas, 1'b1)
      // Window runs again at code zero; a new nonzero code must stay silent
      apply_det({det[24:21], 1'b1, det[19:13], 5'h09, 8'h3C});
      repeat (420) @(posedge clk);
      rdchk(8'h07, 8'h09);
      rdchk(8'h03, 8'h00);
      `CHK(meas, 1'b0)
      $display("test detect_disable done");

      host.write_reg(8'h05, 8'h12);
      host.write_reg(8'h02, 8'h30);
      rdchk(8'h05, 8'h00);
      rdchk(8'h02, 8'h70);
      `CHK(dcd_en, 1'b0)
      `CHK(host.miss, 0)
      $display("test soft_reset done");
      stop_test();
   end

endmodule : test_accessory_detect_irq_status_regs

`default_nettype wire
